// file: common/chip_mode_pkg.sv
// chip mode configuration bank: constants, encodings and register layout
// assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock
// Function
// RULE_01: writing key 56h to the unlock key register opens the protected items
// RULE_02: any other key value closes them again; software should write 00h afterwards
// RULE_03: locked writes to setup register and clock choice are dropped; termination stays writable
// RULE_04: clock register bit 7 disables the port pull resistors when set
// RULE_05: clock register bit 0 picks 12 or 24 MHz input; register resets to 01h
// RULE_06: setup bit 7 picks interrupt output polarity, 1 is active high
// RULE_07: setup bit 6 set drives interrupt pin only at active level, else tristate
// RULE_08: setup bit 5 picks polarity of both dma request outputs
// RULE_09: setup bit 4 picks polarity recognised on both dma acknowledge inputs
// RULE_10: outside party holds acknowledge inactive while its dma channel is off
// RULE_11: with channel mode zero, setup bit 3 also demands chip select for access
// RULE_12: setup bit 2 swaps byte lanes in 16-bit mode; never set in 8-bit mode
// RULE_13: new swap value takes effect only on a read of E9h, also after reset
// RULE_14: setup bits 1:0 select strobe 16-bit, byte-enable 16-bit, or 8-bit bus
package chip_mode_pkg;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_KEY = 8'heb;
  localparam logic [7:0] IDX_CLK = 8'hed;
  localparam logic [7:0] IDX_CFG = 8'hef;
  localparam logic [7:0] IDX_AMC = 8'hf1;
  localparam logic [7:0] IDX_COMMIT = 8'he9;
  localparam logic [7:0] KEY_UNLOCK = 8'h56;
  localparam logic [7:0] KEY_RST = 8'h56;
  localparam logic [7:0] CLK_RST = 8'h01;
  localparam logic [7:0] CLK_RD_MASK = 8'h81;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] AMC_RST = 8'h00;
  localparam int CLK_TERM_BIT = 7;
  localparam int CLK_SEL_BIT = 0;
  localparam int CFG_IRQ_POL = 7;
  localparam int CFG_IRQ_DRV = 6;
  localparam int CFG_REQ_POL = 5;
  localparam int CFG_ACK_POL = 4;
  localparam int CFG_CS_MODE = 3;
  localparam int CFG_SWAP = 2;
  localparam int CFG_BUS_STYLE = 1;
  localparam int CFG_NARROW = 0;
  localparam int AMC_MANUAL = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    BUS_STROBE16 = 3'b001,
    BUS_BE16 = 3'b010,
    BUS_NARROW8 = 3'b100
  } cpu_bus_t;
  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_KEY = 6'b000010,
    SEL_CLK = 6'b000100,
    SEL_CFG = 6'b001000,
    SEL_AMC = 6'b010000,
    SEL_COMMIT = 6'b100000
  } reg_sel_t;
endpackage : chip_mode_pkg

// file: core/irq_pin_stage.sv
// interrupt pin driver with programmable polarity and drive style
// assumes irqReq is an internal active-high level on clk
`timescale 1ns/100ps
module irq_pin_stage
(
  input logic clk,
  input logic reset_n,
  input logic irqReq,
  input logic activeHigh,
  input logic activeOnly,
  output logic pinOut,
  output logic pinOe
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pinOut <= 1'b1;
      pinOe <= 1'b1;
    end
    else
    begin
      pinOut <= irqReq ~^ activeHigh; // [RULE_06]
      pinOe <= ~activeOnly | irqReq; // [RULE_07]
    end
  end
endmodule : irq_pin_stage

// file: core/dma_lane_stage.sv
// one dma channel: request polarity out, acknowledge decode in
// assumes pin inputs are synchronous to clk
`timescale 1ns/100ps
module dma_lane_stage
(
  input logic clk,
  input logic reset_n,
  input logic reqInt,
  input logic reqHigh,
  input logic ackPin,
  input logic ackHigh,
  input logic csMode,
  input logic modeZero,
  input logic csAsserted,
  output logic reqPin,
  output logic access
);
  logic ackActive;
  // no glitch filter: an idle lane relies on the far side parking ack [RULE_10]
  assign ackActive = ackPin ~^ ackHigh; // [RULE_09]
  // ----------------------------------------
  // lane logic
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reqPin <= 1'b1;
      access <= 1'b0;
    end
    else
    begin
      reqPin <= reqInt ~^ reqHigh; // [RULE_08]
      access <= ackActive & (~(modeZero & csMode) | csAsserted); // [RULE_11]
    end
  end
endmodule : dma_lane_stage

// file: core/chip_mode_config_bank.sv
// protected chip mode configuration bank behind an AXI4-Lite slave
// assumes one outstanding write and one outstanding read from the master
`timescale 1ns/100ps
module chip_mode_config_bank #(
  parameter int ADDR_W = 12,
  parameter int CHANNELS = 2
)
(
  input logic clk,
  input logic reset_n,
  input logic wholeChipSoftReset,
  input logic awvalid,
  output logic awready,
  input logic [ADDR_W-1:0] awaddr,
  input logic [2:0] awprot,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [ADDR_W-1:0] araddr,
  input logic [2:0] arprot,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input logic irqReq,
  output logic irqOutN,
  output logic irqOutNOe,
  input logic [CHANNELS-1:0] dmaReqInt,
  output logic [CHANNELS-1:0] dmaReqOut,
  input logic [CHANNELS-1:0] dmaModeZero,
  input logic [CHANNELS-1:0] dmaAckIn,
  input logic chipSelectInN,
  output logic [CHANNELS-1:0] dmaAccess,
  output logic inputClockChoice,
  output logic drivePortResistorDisable,
  output chip_mode_pkg::cpu_bus_t cpuBusMode,
  output logic byteLaneSwap,
  output logic addressAssignManual
);
  import chip_mode_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0] wByte_ff;
  logic wLane0_ff;
  logic [7:0] key_ff;
  logic [7:0] clkSel_ff;
  logic [7:0] cfg_ff;
  logic [7:0] amc_ff;
  logic effSwap_ff;
  cpu_bus_t strobe_style_select_ff;
  logic byteLaneSwap_ff;
  logic wrFire;
  logic wrLoad;
  logic rdFire;
  logic unlocked;
  reg_sel_t wrSel;
  reg_sel_t rdSel;
  logic [7:0] rdByte;
  logic [7:0] nxt_clkSel;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // upper address bits must be clear, so aliases of the bank answer as errors
  function automatic reg_sel_t regSel(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[ADDR_W-1:IDX_LSB+IDX_W] == '0)
    begin
      case (a[IDX_LSB +: IDX_W])
        IDX_KEY: s = SEL_KEY;
        IDX_CLK: s = SEL_CLK;
        IDX_CFG: s = SEL_CFG;
        IDX_AMC: s = SEL_AMC;
        IDX_COMMIT: s = SEL_COMMIT;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : regSel

  function automatic cpu_bus_t busModeOf(input logic [7:0] c);
    cpu_bus_t m;
    m = BUS_STROBE16;
    if (c[CFG_BUS_STYLE])
    begin
      m = BUS_BE16;
    end
    else if (c[CFG_NARROW])
    begin
      m = BUS_NARROW8;
    end
    return m;
  endfunction : busModeOf

  assign wrFire = awHeld_ff & wHeld_ff & ~bvalid_ff;
  assign wrSel = regSel(awAddr_ff);
  // only lane 0 carries the 8-bit registers; other lanes alone store nothing
  assign wrLoad = wrFire & wLane0_ff & ~wholeChipSoftReset;
  assign rdFire = arvalid & arready_ff;
  assign rdSel = regSel(araddr);
  assign unlocked = (key_ff == KEY_UNLOCK); // [RULE_01] [RULE_02]

  // ----------------------------------------
  // write address and data channels
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      awready_ff <= 1'b0;
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
    end
    else
    begin
      awready_ff <= awvalid & ~awready_ff & ~awHeld_ff & ~bvalid_ff;
      if (awvalid & awready_ff)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      else if (wrFire)
      begin
        awHeld_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wready_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      wByte_ff <= 8'h00;
      wLane0_ff <= 1'b0;
    end
    else
    begin
      wready_ff <= wvalid & ~wready_ff & ~wHeld_ff & ~bvalid_ff;
      if (wvalid & wready_ff)
      begin
        wHeld_ff <= 1'b1;
        wByte_ff <= wdata[7:0];
        wLane0_ff <= wstrb[0];
      end
      else if (wrFire)
      begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // write response channel
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channels
  // ----------------------------------------
  always_comb
  begin
    case (rdSel)
      SEL_KEY: rdByte = key_ff;
      SEL_CLK: rdByte = clkSel_ff & CLK_RD_MASK;
      SEL_CFG: rdByte = cfg_ff;
      SEL_AMC: rdByte = 8'h00;
      SEL_COMMIT: rdByte = 8'h00;
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      arready_ff <= 1'b0;
    end
    else
    begin
      arready_ff <= arvalid & ~arready_ff & ~rvalid_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end
    else if (rdFire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h0, rdByte};
      rresp_ff <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // unlock key
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n || wholeChipSoftReset)
    begin
      key_ff <= KEY_RST;
    end
    else if (wrLoad && wrSel == SEL_KEY)
    begin
      key_ff <= wByte_ff; // [RULE_01] [RULE_02]
    end
  end

  // ----------------------------------------
  // clock choice and termination
  // ----------------------------------------
  always_comb
  begin
    nxt_clkSel = clkSel_ff;
    if (wrLoad && wrSel == SEL_CLK)
    begin
      nxt_clkSel[CLK_TERM_BIT] = wByte_ff[CLK_TERM_BIT]; // [RULE_03] [RULE_04]
      if (unlocked)
      begin
        nxt_clkSel[CLK_SEL_BIT] = wByte_ff[CLK_SEL_BIT]; // [RULE_03] [RULE_05]
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || wholeChipSoftReset)
    begin
      clkSel_ff <= CLK_RST; // [RULE_05]
    end
    else
    begin
      clkSel_ff <= nxt_clkSel & CLK_RD_MASK;
    end
  end

  // ----------------------------------------
  // chip setup register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n || wholeChipSoftReset)
    begin
      cfg_ff <= CFG_RST; // [RULE_13]
    end
    else if (wrLoad && wrSel == SEL_CFG && unlocked)
    begin
      cfg_ff <= wByte_ff; // [RULE_03]
    end
  end

  // soft reset leaves the live swap alone; only reset_n and the commit read move it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      effSwap_ff <= CFG_RST[CFG_SWAP];
    end
    else if (rdFire && rdSel == SEL_COMMIT)
    begin
      effSwap_ff <= cfg_ff[CFG_SWAP]; // [RULE_13]
    end
  end

  // ----------------------------------------
  // address mode control, write only
  // ----------------------------------------
  // reserved bits must be written 0, so only the mode bit is kept
  always_ff @(posedge clk)
  begin
    if (!reset_n || wholeChipSoftReset)
    begin
      amc_ff <= AMC_RST;
    end
    else if (wrLoad && wrSel == SEL_AMC)
    begin
      amc_ff <= wByte_ff & (8'h01 << AMC_MANUAL);
    end
  end

  // ----------------------------------------
  // bus mode outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      strobe_style_select_ff <= BUS_STROBE16;
      byteLaneSwap_ff <= 1'b0;
    end
    else
    begin
      strobe_style_select_ff <= busModeOf(cfg_ff); // [RULE_14]
      // swap has no meaning on an 8-bit bus, so it is forced off there
      byteLaneSwap_ff <= effSwap_ff & (busModeOf(cfg_ff) != BUS_NARROW8); // [RULE_12]
    end
  end

  // ----------------------------------------
  // pin stages
  // ----------------------------------------
  irq_pin_stage u_irq
  (
    .clk(clk),
    .reset_n(reset_n),
    .irqReq(irqReq),
    .activeHigh(cfg_ff[CFG_IRQ_POL]),
    .activeOnly(cfg_ff[CFG_IRQ_DRV]),
    .pinOut(irqOutN),
    .pinOe(irqOutNOe)
  );

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_lane
      dma_lane_stage u_lane
      (
        .clk(clk),
        .reset_n(reset_n),
        .reqInt(dmaReqInt[ch]),
        .reqHigh(cfg_ff[CFG_REQ_POL]),
        .ackPin(dmaAckIn[ch]),
        .ackHigh(cfg_ff[CFG_ACK_POL]),
        .csMode(cfg_ff[CFG_CS_MODE]),
        .modeZero(dmaModeZero[ch]),
        .csAsserted(~chipSelectInN),
        .reqPin(dmaReqOut[ch]),
        .access(dmaAccess[ch])
      );
    end
  endgenerate

  // ----------------------------------------
  // output wiring
  // ----------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign inputClockChoice = clkSel_ff[CLK_SEL_BIT];
  assign drivePortResistorDisable = clkSel_ff[CLK_TERM_BIT];
  assign cpuBusMode = strobe_style_select_ff;
  assign byteLaneSwap = byteLaneSwap_ff;
  assign addressAssignManual = amc_ff[AMC_MANUAL];
endmodule : chip_mode_config_bank

// file: verif/chip_mode_monitor.sv
// ------------------------------------------------------------
// port checks for the config bank
// ------------------------------------------------------------
// assumes bind from the bench top, one clock
`timescale 1ns/100ps
module chip_mode_monitor #(
  parameter int CHANNELS = 2
)
(
  input logic clk,
  input logic reset_n,
  input logic wholeChipSoftReset,
  input logic bvalid,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic irqReq,
  input logic irqOutN,
  input logic irqOutNOe,
  input logic [CHANNELS-1:0] dmaReqInt,
  input logic [CHANNELS-1:0] dmaReqOut,
  input logic [CHANNELS-1:0] dmaAckIn,
  input logic chipSelectInN,
  input logic [CHANNELS-1:0] dmaAccess,
  input logic inputClockChoice,
  input logic drivePortResistorDisable,
  input chip_mode_pkg::cpu_bus_t cpuBusMode,
  input logic byteLaneSwap
);
  import chip_mode_pkg::*;
  logic quiet;
  logic calm;
  logic q1_ff;
  logic q2_ff;
  // settings may only move near a response or a reset
  assign quiet = reset_n && !bvalid && !rvalid && !wholeChipSoftReset;
  assign calm = quiet && q1_ff && q2_ff;
  always_ff @(posedge clk)
  begin
    q1_ff <= quiet;
    q2_ff <= q1_ff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence arTake;
    arvalid && arready;
  endsequence
  AST_READ_ANSWER: assert property (arTake |=> rvalid)
    else $error("read not answered next cycle");
  AST_IRQ_FOLLOW: assert property (calm && $past(irqReq) != $past(irqReq, 2)
    |-> irqOutN != $past(irqOutN)) else $error("irq pin did not follow");
  AST_IRQ_OE: assert property (calm && $past(irqReq) |-> irqOutNOe)
    else $error("irq pin released while active");
  AST_DREQ: assert property (calm |-> (dmaReqOut ^ $past(dmaReqOut))
    == ($past(dmaReqInt) ^ $past(dmaReqInt, 2))) else $error("dma request pin wrong");
  AST_DACK: assert property (calm && $past(!chipSelectInN) && $past(!chipSelectInN, 2)
    |-> (dmaAccess ^ $past(dmaAccess)) == ($past(dmaAckIn) ^ $past(dmaAckIn, 2)))
    else $error("dma access did not follow ack");
  AST_MODE_ONEHOT: assert property ($onehot(cpuBusMode))
    else $error("bus mode not one-hot");
  AST_CLK_HOLD: assert property ($changed(inputClockChoice) |-> !calm)
    else $error("clock choice moved on its own");
  AST_TERM_HOLD: assert property ($changed(drivePortResistorDisable) |-> !calm)
    else $error("termination moved on its own");
  AST_SWAP_NARROW: assert property (calm && cpuBusMode == BUS_NARROW8
    && $past(cpuBusMode) == BUS_NARROW8 |-> !byteLaneSwap) else $error("swap in 8-bit");
endmodule : chip_mode_monitor

// file: verif/host_cpu_model.sv
// ------------------------------------------------------------
// AXI4-Lite host master
// ------------------------------------------------------------
// assumes one access at a time, called from the bench
`timescale 1ns/100ps
module host_cpu_model
(
  input logic clk,
  output logic awvalid,
  input logic awready,
  output logic [11:0] awaddr,
  output logic wvalid,
  input logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input logic bvalid,
  output logic bready,
  input logic [1:0] bresp,
  output logic arvalid,
  input logic arready,
  output logic [11:0] araddr,
  input logic rvalid,
  output logic rready,
  input logic [31:0] rdata,
  input logic [1:0] rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // released address and data lines show inverted values, not the last ones; wstrb keeps its last one
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    {awaddr, wdata, wstrb} <= {a, d, s};
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end while (bready);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready)
      begin
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
      end
    end while (rready);
  endtask : rd
endmodule : host_cpu_model

// file: verif/chip_mode_config_bank_test.sv
// ------------------------------------------------------------
// self-checking bench for the config bank
// ------------------------------------------------------------
// assumes host model drives the bus, bench drives the pins
`timescale 1ns/100ps
module chip_mode_config_bank_test;
  import chip_mode_pkg::*;
  localparam int CHANNELS = 2;
  logic clk, reset_n, wholeChipSoftReset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irqReq, irqOutN, irqOutNOe, chipSelectInN;
  logic inputClockChoice, drivePortResistorDisable, byteLaneSwap, addressAssignManual;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, dmaReqInt, dmaReqOut, dmaModeZero, dmaAckIn, dmaAccess, q;
  cpu_bus_t cpuBusMode;
  logic [7:0] v;
  int num_errors, num_checks, keyM, clkM, cfgM, amcM, swapM;
  chip_mode_config_bank #(.ADDR_W(12), .CHANNELS(CHANNELS)) DUT (.clk, .reset_n,
    .wholeChipSoftReset, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .irqReq, .irqOutN, .irqOutNOe, .dmaReqInt, .dmaReqOut,
    .dmaModeZero, .dmaAckIn, .chipSelectInN, .dmaAccess, .inputClockChoice,
    .drivePortResistorDisable, .cpuBusMode, .byteLaneSwap, .addressAssignManual);
  host_cpu_model host (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [1:0] rs(input logic [7:0] i);
    return (i inside {IDX_KEY, IDX_CLK, IDX_CFG, IDX_AMC, IDX_COMMIT}) ? RESP_OKAY : RESP_SLVERR;
  endfunction : rs
  task wreg(input logic [7:0] i, input logic [7:0] d);
    host.wr({2'h0, i, 2'h0}, {24'h0, d}, 4'h1, resp);
    chk({30'h0, resp}, {30'h0, rs(i)});
    if (i == IDX_CLK)
      clkM = (keyM == 'h56) ? (d & 'h81) : ((d & 'h80) | (clkM & 1));
    if (i == IDX_CFG && keyM == 'h56)
      cfgM = 32'(d);
    if (i == IDX_KEY)
      keyM = 32'(d);
    if (i == IDX_AMC)
      amcM = 32'(d[4]);
  endtask : wreg
  task rreg(input logic [7:0] i);
    host.rd({2'h0, i, 2'h0}, rd, resp);
    chk({30'h0, resp}, {30'h0, rs(i)});
    chk(rd, (i == IDX_KEY) ? keyM : (i == IDX_CLK) ? clkM : (i == IDX_CFG) ? cfgM : 0);
    if (i == IDX_COMMIT)
      swapM = 32'(cfgM[2]);
  endtask : rreg
  task outs;
    logic [2:0] m;
    repeat (2) @(posedge clk);
    #1;
    m = cfgM[1] ? BUS_BE16 : cfgM[0] ? BUS_NARROW8 : BUS_STROBE16;
    // concatenation keeps each expectation at its own width, so ~^ cannot set upper bits
    chk({29'h0, cpuBusMode}, {29'h0, m});
    chk({31'h0, byteLaneSwap}, {31'h0, swapM[0] && m != BUS_NARROW8});
    chk({31'h0, inputClockChoice}, {31'h0, clkM[0]});
    chk({31'h0, drivePortResistorDisable}, {31'h0, clkM[7]});
    chk({31'h0, addressAssignManual}, {31'h0, amcM[0]});
    chk({31'h0, irqOutN}, {31'h0, irqReq ~^ cfgM[7]});
    chk({31'h0, irqOutNOe}, {31'h0, !cfgM[6] || irqReq});
    chk({30'h0, dmaReqOut}, {30'h0, dmaReqInt ~^ {2{cfgM[5]}}});
    chk({30'h0, dmaAccess}, {30'h0, (dmaAckIn ~^ {2{cfgM[4]}})
      & (~(dmaModeZero & {2{cfgM[3]}}) | {2{!chipSelectInN}})});
  endtask : outs
  task pins;
    @(posedge clk);
    q = 2'($urandom);
    {irqReq, dmaModeZero, chipSelectInN} <= 4'($urandom);
    dmaReqInt <= q;
    dmaAckIn <= (2'($urandom) & q) ^ {2{!cfgM[4]}};
  endtask : pins
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    {reset_n, wholeChipSoftReset, irqReq, dmaReqInt, dmaModeZero} = 7'h00;
    // acknowledge parked at its inactive level for the reset polarity
    dmaAckIn = 2'h3;
    chipSelectInN = 1'b1;
    {num_errors, num_checks, cfgM, amcM, swapM} = '0;
    {keyM, clkM} = {32'h56, 32'h1};
    void'($urandom(88));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    outs();
    rreg(IDX_CLK);
    rreg(IDX_CFG);
    rreg(IDX_AMC);
    rreg(8'hec);
    wreg(IDX_KEY, 8'h00);
    wreg(IDX_CFG, 8'h0f);
    wreg(IDX_CLK, 8'h80);
    wreg(8'hec, 8'h12);
    wreg(IDX_COMMIT, 8'h04);
    rreg(IDX_KEY);
    outs();
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($urandom);
      v[1:0] = 2'(i);
      if (v[1:0] == 2'b01)
        v[2] = 1'b0;
      wreg(IDX_KEY, i[2] ? 8'h56 : 8'($urandom));
      wreg(IDX_CFG, v);
      wreg(IDX_CLK, 8'($urandom));
      wreg(IDX_AMC, 8'($urandom) & 8'h10);
      if (i[0])
        rreg(IDX_COMMIT);
      rreg(IDX_CFG);
      rreg(IDX_CLK);
      pins();
      outs();
      if (i == 9)
      begin
        @(posedge clk);
        wholeChipSoftReset <= 1'b1;
        @(posedge clk);
        wholeChipSoftReset <= 1'b0;
        {keyM, clkM, cfgM, amcM} = {32'h56, 32'h1, 64'h0};
        outs();
      end
    end
    summarize();
  end
endmodule : chip_mode_config_bank_test
bind chip_mode_config_bank chip_mode_monitor #(.CHANNELS(CHANNELS)) mon (.clk, .reset_n,
  .wholeChipSoftReset, .bvalid, .arvalid, .arready, .rvalid, .irqReq, .irqOutN, .irqOutNOe,
  .dmaReqInt, .dmaReqOut, .dmaAckIn, .chipSelectInN, .dmaAccess, .inputClockChoice,
  .drivePortResistorDisable, .cpuBusMode, .byteLaneSwap);
